// ### inc/cpu_exec_pkg.sv
// =============================================================================
// Shared constants and types of the instruction execution core.
// =============================================================================
package cpu_exec_pkg;

  // ===========================================================================
  // Timing: one bus cycle lasts a whole number of reference clocks.
  // ===========================================================================
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          BUS_CYCLE_NS  = 80;
  localparam int          CYCLE_DIV     = (BUS_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0]  DIV_LAST      = 2'(CYCLE_DIV - 1);

  // ===========================================================================
  // Opcodes.
  // ===========================================================================
  localparam logic [7:0]  OP_PREFIX_Y   = 8'h18;
  localparam logic [7:0]  OP_INS        = 8'h31;
  localparam logic [7:0]  OP_INX        = 8'h08;
  localparam logic [7:0]  OP_JMP_EXT    = 8'h7e;
  localparam logic [7:0]  OP_JMP_IDX    = 8'h6e;
  localparam logic [7:0]  OP_JSR_DIR    = 8'h9d;
  localparam logic [7:0]  OP_JSR_EXT    = 8'hbd;
  localparam logic [7:0]  OP_JSR_IDX    = 8'had;
  localparam logic [7:0]  OP_LDA_IMM    = 8'h86;
  localparam logic [7:0]  OP_LDA_DIR    = 8'h96;
  localparam logic [7:0]  OP_LDA_EXT    = 8'hb6;
  localparam logic [7:0]  OP_LDA_IDX    = 8'ha6;
  localparam logic [7:0]  OP_LDB_IMM    = 8'hc6;
  localparam logic [7:0]  OP_LDB_DIR    = 8'hd6;
  localparam logic [7:0]  OP_LDB_EXT    = 8'hf6;
  localparam logic [7:0]  OP_LDB_IDX    = 8'he6;

  // ===========================================================================
  // Addresses, increments and condition-code bit positions.
  // ===========================================================================
  localparam logic [15:0] ADDR_IDLE     = 16'hffff;
  localparam logic [15:0] ONE16         = 16'h0001;
  localparam logic [15:0] ZERO16        = 16'h0000;
  localparam logic [15:0] RET_INC_SHORT = 16'h0002;
  localparam logic [15:0] RET_INC_LONG  = 16'h0003;
  localparam int          CCR_C         = 0;
  localparam int          CCR_V         = 1;
  localparam int          CCR_Z         = 2;
  localparam int          CCR_N         = 3;

  // ===========================================================================
  // Reset values.
  // ===========================================================================
  localparam logic [15:0] RST_PC        = 16'h0000;
  localparam logic [15:0] RST_SP        = 16'h00ff;
  localparam logic [7:0]  RST_CCR       = 8'hd0;

  // ===========================================================================
  // APB register byte offsets and field positions.
  // ===========================================================================
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_PC        = 8'h08;
  localparam logic [7:0]  REG_SP        = 8'h0c;
  localparam logic [7:0]  REG_X         = 8'h10;
  localparam logic [7:0]  REG_Y         = 8'h14;
  localparam logic [7:0]  REG_ACC       = 8'h18;
  localparam logic [7:0]  REG_CCR       = 8'h1c;
  localparam int          CTRL_RUN      = 0;
  localparam int          STAT_BUSY     = 0;
  localparam int          STAT_ILLEGAL  = 1;

  // ===========================================================================
  // Enumerations.
  // ===========================================================================
  typedef enum logic [9:0] {
    S_IDLE    = 10'b0000000001,
    S_FETCH   = 10'b0000000010,
    S_INHR    = 10'b0000000100,
    S_STACKRD = 10'b0000001000,
    S_OPND1   = 10'b0000010000,
    S_OPND2   = 10'b0000100000,
    S_DUMMY   = 10'b0001000000,
    S_MEM     = 10'b0010000000,
    S_PUSH_LO = 10'b0100000000,
    S_PUSH_HI = 10'b1000000000
  } state_t;

  typedef enum logic [6:0] {
    K_INS = 7'b0000001,
    K_INX = 7'b0000010,
    K_INY = 7'b0000100,
    K_JMP = 7'b0001000,
    K_JSR = 7'b0010000,
    K_LDA = 7'b0100000,
    K_LDB = 7'b1000000
  } kind_t;

  typedef enum logic [4:0] {
    M_INH = 5'b00001,
    M_IMM = 5'b00010,
    M_DIR = 5'b00100,
    M_EXT = 5'b01000,
    M_IDX = 5'b10000
  } mode_t;

endpackage

// ### hw/cycle_tick.sv
`timescale 1ns/10ps
// =============================================================================
// Bus cycle divider: one-cycle pulse on the last clock of each bus cycle.
// =============================================================================
module cycle_tick
(
  input  wire logic ref_clk,   // Reference clock.
  input  wire logic sys_rst,   // Synchronous reset, active high.
  output logic      tick       // One-clock pulse ending a bus cycle.
);
  import cpu_exec_pkg::*;

  typedef struct packed {
    logic [1:0] cnt;
    logic       tick;
  } div_t;

  div_t s;
  div_t next_s;

  // Count clocks and flag the last one of each bus cycle.
  always_comb
  begin
    next_s      = s;
    next_s.tick = (s.cnt == DIV_LAST);
    next_s.cnt  = (s.cnt == DIV_LAST) ? 2'h0 : 2'(s.cnt + 2'h1);
  end

  // Register the divider state.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign tick = s.tick;

endmodule // cycle_tick

// ### hw/incr_jump_call_load_exec.sv
`timescale 1ns/10ps
// What this block does
// - stack_ptr_increment 31 adds one to stack pointer, three reads, flags untouched.
// - x_index_increment 08 adds one to X, three reads, third at FFFF.
// - Index increments update only the zero flag, set when result is 0000.
// - y_index_increment is 18 then 08, adds one to Y, four reads.
// - jump_op loads program counter with effective address; 7E, 6E, 18 6E.
// - subroutine_call return address is start plus 3 (ext, Y) or 2.
// - Return address pushed low byte at SP, high at SP-1, decrementing.
// - After pushes SP is next empty slot; PC gets effective address.
// - subroutine_call forms 9D, BD, AD, 18 AD take 5, 6, 6, 7 cycles.
// - load_acc_a and load_acc_b copy memory or immediate byte into accumulator.
// - Load sets N from bit 7, Z when zero, clears V.
// - Load opcodes 86 96 B6 A6 18A6 and C6 D6 F6 E6 18E6, 2-5 cycles.
module incr_jump_call_load_exec
(
  input  wire logic        ref_clk,    // Reference clock, 50 MHz.
  input  wire logic        sys_rst,    // Synchronous reset, active high.
  output logic [15:0]      mem_addr,   // Bus cycle address.
  output logic             mem_rw,     // High for read, low for write.
  output logic [7:0]       mem_wdata,  // Write data of a write cycle.
  input  wire logic [7:0]  mem_rdata,  // Read data, sampled at cycle end.
  output logic             bus_tick,   // Pulse on the last clock of a bus cycle.
  input  wire logic        psel,       // APB select.
  input  wire logic        penable,    // APB enable.
  input  wire logic        pwrite,     // APB write direction.
  input  wire logic [7:0]  paddr,      // APB byte address.
  input  wire logic [31:0] pwdata,     // APB write data.
  output logic [31:0]      prdata,     // APB read data.
  output logic             pready,     // APB ready.
  output logic             pslverr     // APB error on unmapped address.
);
  import cpu_exec_pkg::*;

  // ===========================================================================
  // Types.
  // ===========================================================================
  typedef struct packed {
    logic  ok;
    kind_t kind;
    mode_t mode;
  } dec_t;

  typedef struct packed {
    state_t      st;
    kind_t       kind;
    mode_t       mode;
    logic        pre;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] ea;
    logic [15:0] op_addr;
    logic [15:0] ret;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  condition_code_reg;
    logic [15:0] addr;
    logic        rw;
    logic [7:0]  wdata;
    logic        run;
    logic        illegal;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } core_t;

  core_t s;
  core_t next_s;
  logic  tick;
  logic  done;
  dec_t  dec;
  logic  access;
  logic  idle_regs;

  // ===========================================================================
  // Decode of one opcode byte, with or without the Y prefix.
  // ===========================================================================
  function automatic dec_t decode(input logic [7:0] op, input logic pre);
    dec_t d;
    d = '{ok: 1'b1, kind: K_INS, mode: M_INH};
    if (!pre && op == OP_INS)
      d = '{ok: 1'b1, kind: K_INS, mode: M_INH};
    else if (op == OP_INX)
      d = '{ok: 1'b1, kind: pre ? K_INY : K_INX, mode: M_INH};
    else if (!pre && op == OP_JMP_EXT)
      d = '{ok: 1'b1, kind: K_JMP, mode: M_EXT};
    else if (op == OP_JMP_IDX)
      d = '{ok: 1'b1, kind: K_JMP, mode: M_IDX};
    else if (!pre && op == OP_JSR_DIR)
      d = '{ok: 1'b1, kind: K_JSR, mode: M_DIR};
    else if (!pre && op == OP_JSR_EXT)
      d = '{ok: 1'b1, kind: K_JSR, mode: M_EXT};
    else if (op == OP_JSR_IDX)
      d = '{ok: 1'b1, kind: K_JSR, mode: M_IDX};
    else if (!pre && op == OP_LDA_IMM)
      d = '{ok: 1'b1, kind: K_LDA, mode: M_IMM};
    else if (!pre && op == OP_LDA_DIR)
      d = '{ok: 1'b1, kind: K_LDA, mode: M_DIR};
    else if (!pre && op == OP_LDA_EXT)
      d = '{ok: 1'b1, kind: K_LDA, mode: M_EXT};
    else if (op == OP_LDA_IDX)
      d = '{ok: 1'b1, kind: K_LDA, mode: M_IDX};
    else if (!pre && op == OP_LDB_IMM)
      d = '{ok: 1'b1, kind: K_LDB, mode: M_IMM};
    else if (!pre && op == OP_LDB_DIR)
      d = '{ok: 1'b1, kind: K_LDB, mode: M_DIR};
    else if (!pre && op == OP_LDB_EXT)
      d = '{ok: 1'b1, kind: K_LDB, mode: M_EXT};
    else if (op == OP_LDB_IDX)
      d = '{ok: 1'b1, kind: K_LDB, mode: M_IDX};
    else
      d.ok = 1'b0;
    return d;
  endfunction

  // Flags after a byte load; carry and the upper bits are carried over.
  function automatic logic [7:0] load_flags(input logic [7:0] condition_code_reg, input logic [7:0] data);
    logic [7:0] c;
    c        = condition_code_reg;
    c[CCR_N] = data[7];
    c[CCR_Z] = (data == 8'h00);
    c[CCR_V] = 1'b0;
    return c;
  endfunction

  // ===========================================================================
  // Bus cycle divider.
  // ===========================================================================
  cycle_tick u_tick
  (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .tick    (tick)
  );

  // ===========================================================================
  // Next state: APB register access first, then the execution sequencer.
  // ===========================================================================
  // PC, SP, X, Y, ACC and CCR move only while the core is parked, so software never races the
  // sequencer; writes to them that arrive while running are dropped without an error.
  always_comb
  begin
    next_s         = s;
    done           = 1'b0;
    dec            = decode(mem_rdata, s.pre);
    access         = psel && penable;
    idle_regs      = (s.st == S_IDLE) && !s.run;
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0;

    // First access cycle: latch read data and the error answer.
    if (access && !s.pready)
    begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0;
      if (paddr == REG_CTRL)
        next_s.prdata[CTRL_RUN] = s.run;
      else if (paddr == REG_STATUS)
        next_s.prdata[STAT_ILLEGAL:STAT_BUSY] = {s.illegal, s.st != S_IDLE};
      else if (paddr == REG_PC)
        next_s.prdata[15:0] = s.pc;
      else if (paddr == REG_SP)
        next_s.prdata[15:0] = s.sp;
      else if (paddr == REG_X)
        next_s.prdata[15:0] = s.x;
      else if (paddr == REG_Y)
        next_s.prdata[15:0] = s.y;
      else if (paddr == REG_ACC)
        next_s.prdata[15:0] = {s.a, s.b};
      else if (paddr == REG_CCR)
        next_s.prdata[7:0] = s.condition_code_reg;
      else
        next_s.pslverr = 1'b1;
    end

    // Completing write cycle: the write takes effect here only.
    if (access && s.pready && pwrite)
    begin
      if (paddr == REG_CTRL)
        next_s.run = pwdata[CTRL_RUN];
      else if (paddr == REG_STATUS && pwdata[STAT_ILLEGAL])
        next_s.illegal = 1'b0;
      else if (paddr == REG_PC && idle_regs)
        next_s.pc = pwdata[15:0];
      else if (paddr == REG_SP && idle_regs)
        next_s.sp = pwdata[15:0];
      else if (paddr == REG_X && idle_regs)
        next_s.x = pwdata[15:0];
      else if (paddr == REG_Y && idle_regs)
        next_s.y = pwdata[15:0];
      else if (paddr == REG_ACC && idle_regs)
        {next_s.a, next_s.b} = pwdata[15:0];
      else if (paddr == REG_CCR && idle_regs)
        next_s.condition_code_reg = pwdata[7:0];
    end

    // Sequencer: each bus cycle ends on a tick, when read data is valid.
    if (tick)
    begin
      next_s.rw    = 1'b1;
      next_s.wdata = 8'h00;
      case (s.st)
        S_IDLE:
          done = 1'b1;
        S_FETCH:
        begin
          next_s.pc = 16'(s.pc + ONE16);
          if (!s.pre)
            next_s.op_addr = s.pc;
          if (!s.pre && mem_rdata == OP_PREFIX_Y)
          begin
            next_s.pre  = 1'b1;
            next_s.addr = 16'(s.pc + ONE16);
          end
          else if (!dec.ok)
          begin
            // Unknown opcodes park the core and leave a sticky flag.
            next_s.illegal = 1'b1;
            next_s.run     = 1'b0;
            done           = 1'b1;
          end
          else
          begin
            next_s.kind = dec.kind;
            next_s.mode = dec.mode;
            next_s.st   = (dec.mode == M_INH) ? S_INHR : S_OPND1;
            next_s.addr = 16'(s.pc + ONE16);
          end
        end
        S_INHR:
        begin
          // The byte after the opcode is read and thrown away.
          if (s.kind == K_INS)
          begin
            next_s.st   = S_STACKRD;
            next_s.addr = s.sp;
          end
          else
          begin
            next_s.st   = S_DUMMY;
            next_s.addr = ADDR_IDLE;
          end
        end
        S_STACKRD:
        begin
          next_s.sp = 16'(s.sp + ONE16);
          done      = 1'b1;
        end
        S_OPND1:
        begin
          next_s.pc = 16'(s.pc + ONE16);
          if (s.mode == M_IMM)
          begin
            if (s.kind == K_LDA)
              next_s.a = mem_rdata;
            else
              next_s.b = mem_rdata;
            next_s.condition_code_reg = load_flags(s.condition_code_reg, mem_rdata);
            done       = 1'b1;
          end
          else if (s.mode == M_DIR)
          begin
            next_s.ea   = {8'h00, mem_rdata};
            next_s.st   = S_MEM;
            next_s.addr = {8'h00, mem_rdata};
          end
          else if (s.mode == M_EXT)
          begin
            next_s.ea[15:8] = mem_rdata;
            next_s.st       = S_OPND2;
            next_s.addr     = 16'(s.pc + ONE16);
          end
          else
          begin
            // Indexed offset is unsigned; the add wraps at 64 KiB.
            next_s.ea   = 16'((s.pre ? s.y : s.x) + {8'h00, mem_rdata});
            next_s.st   = S_DUMMY;
            next_s.addr = ADDR_IDLE;
          end
        end
        S_OPND2:
        begin
          next_s.pc      = 16'(s.pc + ONE16);
          next_s.ea[7:0] = mem_rdata;
          if (s.kind == K_JMP)
          begin
            next_s.pc = {s.ea[15:8], mem_rdata};
            done      = 1'b1;
          end
          else
          begin
            next_s.st   = S_MEM;
            next_s.addr = {s.ea[15:8], mem_rdata};
          end
        end
        S_DUMMY:
        begin
          if (s.kind == K_INX)
          begin
            next_s.x          = 16'(s.x + ONE16);
            next_s.condition_code_reg[CCR_Z] = (16'(s.x + ONE16) == ZERO16);
            done              = 1'b1;
          end
          else if (s.kind == K_INY)
          begin
            next_s.y          = 16'(s.y + ONE16);
            next_s.condition_code_reg[CCR_Z] = (16'(s.y + ONE16) == ZERO16);
            done              = 1'b1;
          end
          else if (s.kind == K_JMP)
          begin
            next_s.pc = s.ea;
            done      = 1'b1;
          end
          else
          begin
            next_s.st   = S_MEM;
            next_s.addr = s.ea;
          end
        end
        S_MEM:
        begin
          if (s.kind == K_JSR)
          begin
            // The operand read of a call is discarded before the pushes.
            next_s.ret   = 16'(s.op_addr + (((s.mode == M_DIR) || !s.pre && s.mode == M_IDX)
                             ? RET_INC_SHORT : RET_INC_LONG));
            next_s.st    = S_PUSH_LO;
            next_s.addr  = s.sp;
            next_s.rw    = 1'b0;
            next_s.wdata = next_s.ret[7:0];
          end
          else
          begin
            if (s.kind == K_LDA)
              next_s.a = mem_rdata;
            else
              next_s.b = mem_rdata;
            next_s.condition_code_reg = load_flags(s.condition_code_reg, mem_rdata);
            done       = 1'b1;
          end
        end
        S_PUSH_LO:
        begin
          next_s.sp    = 16'(s.sp - ONE16);
          next_s.st    = S_PUSH_HI;
          next_s.addr  = 16'(s.sp - ONE16);
          next_s.rw    = 1'b0;
          next_s.wdata = s.ret[15:8];
        end
        S_PUSH_HI:
        begin
          next_s.sp = 16'(s.sp - ONE16);
          next_s.pc = s.ea;
          done      = 1'b1;
        end
        default:
          done = 1'b1;
      endcase

      // Instruction boundary: fetch the next opcode or park on an idle read.
      if (done)
      begin
        next_s.pre  = 1'b0;
        next_s.st   = next_s.run ? S_FETCH : S_IDLE;
        next_s.addr = next_s.run ? next_s.pc : ADDR_IDLE;
      end
    end
  end

  // ===========================================================================
  // State register.
  // ===========================================================================
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s      <= '0;
      s.st   <= S_IDLE;
      s.kind <= K_INS;
      s.mode <= M_INH;
      s.pc   <= RST_PC;
      s.sp   <= RST_SP;
      s.condition_code_reg  <= RST_CCR;
      s.addr <= ADDR_IDLE;
      s.rw   <= 1'b1;
    end
    else
      s <= next_s;
  end

  // Outputs are taken straight from the state register; bus_tick from the divider's register.
  assign mem_addr  = s.addr;
  assign mem_rw    = s.rw;
  assign mem_wdata = s.wdata;
  assign bus_tick  = tick;
  assign prdata    = s.prdata;
  assign pready    = s.pready;
  assign pslverr   = s.pslverr;

endmodule // incr_jump_call_load_exec

// ### sim/incr_jump_call_load_exec_checker.sv
`timescale 1ns/10ps
// =============================================================================
// Port checks of the execution core: bus cycle framing and the APB slave.
// =============================================================================
module incr_jump_call_load_exec_checker
(
  input wire logic        ref_clk,    // Clock.
  input wire logic        sys_rst,    // Reset.
  input wire logic [15:0] mem_addr,   // Bus address.
  input wire logic        mem_rw,     // Bus direction.
  input wire logic [7:0]  mem_wdata,  // Bus write data.
  input wire logic [7:0]  mem_rdata,  // Bus read data.
  input wire logic        bus_tick,   // Bus cycle end.
  input wire logic        psel,       // APB select.
  input wire logic        penable,    // APB enable.
  input wire logic        pwrite,     // APB direction.
  input wire logic [7:0]  paddr,      // APB address.
  input wire logic [31:0] pwdata,     // APB write data.
  input wire logic [31:0] prdata,     // APB read data.
  input wire logic        pready,     // APB ready.
  input wire logic        pslverr     // APB error.
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Bus cycles last four clocks and the address only moves after a tick.
  AST_TICK_PERIOD: assert property (bus_tick |=> !bus_tick [*3] ##1 bus_tick)
    else $error("bus tick spacing wrong");
  AST_ADDR_HOLD: assert property (!bus_tick |=> $stable(mem_addr) && $stable(mem_rw))
    else $error("bus address moved inside a cycle");
  // Stack pushes come as a pair, the second one byte lower, then a read.
  AST_PUSH_PAIR: assert property ($fell(mem_rw) |-> ##4 (!mem_rw && mem_addr == $past(mem_addr, 4) - 16'h0001)
    ##4 mem_rw)
    else $error("push pair malformed");
  AST_IDLE_READ: assert property (mem_addr == 16'hffff |-> mem_rw)
    else $error("internal cycle not a read");
  AST_READ_WDATA: assert property (mem_rw |-> mem_wdata == 8'h00)
    else $error("write data driven on a read");
  // The APB slave answers after exactly one wait state, for one cycle.
  AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("apb ready held");
  AST_READY_CAUSE: assert property ($rose(pready) |-> $past(psel && penable))
    else $error("apb ready without access");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("apb error outside ready");
endmodule // incr_jump_call_load_exec_checker

bind incr_jump_call_load_exec incr_jump_call_load_exec_checker u_chk (.ref_clk, .sys_rst, .mem_addr, .mem_rw,
  .mem_wdata, .mem_rdata, .bus_tick, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

// ### sim/mem_model.sv
`timescale 1ns/10ps
// =============================================================================
// Zero-wait memory on the core's bus.
// =============================================================================
module mem_model
(
  input  wire logic        ref_clk,    // Clock.
  input  wire logic [15:0] mem_addr,   // Bus address.
  input  wire logic        mem_rw,     // High for read.
  input  wire logic [7:0]  mem_wdata,  // Write data.
  input  wire logic        bus_tick,   // Cycle end.
  output logic [7:0]       mem_rdata   // Read data.
);
  logic [7:0] ram [0:65535];
  // On a write cycle the read lines carry the inverted write data, not stale data.
  assign mem_rdata = mem_rw ? ram[mem_addr] : ~mem_wdata;
  // A write lands at the edge that ends its bus cycle.
  always @(posedge ref_clk)
  begin
    if (bus_tick && !mem_rw)
      ram[mem_addr] <= mem_wdata;
  end
endmodule // mem_model

// ### sim/incr_jump_call_load_exec_tb.sv
`timescale 1ns/10ps
// =============================================================================
// Runs two short programs and checks the architectural state over APB.
// =============================================================================
module incr_jump_call_load_exec_tb;
  import cpu_exec_pkg::*;
  logic              ref_clk, sys_rst, psel, penable, pwrite, bus_tick, mem_rw, pready, pslverr, e;
  logic [7:0]        paddr, mem_wdata, mem_rdata;
  logic [15:0]       mem_addr;
  logic [31:0]       pwdata, prdata, q;
  int                fails, num_checks, cyc, n;
  logic [0:23][7:0]  code = {8'h86, 8'h80, 8'hc6, 8'h00, 8'h08, 8'h31, 8'h18, 8'h08, 8'hbd, 8'h00, 8'h10,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h18, 8'he6, 8'hff, 8'h96, 8'h40, 8'h7e, 8'h00, 8'h15};
  // Second program as address and byte pairs: direct and indexed calls and jumps, then a bad opcode.
  logic [0:13][23:0] prog2 = {24'h00309d, 24'h003150, 24'h00506e, 24'h00515f, 24'h0060b6, 24'h006100,
    24'h006240, 24'h006318, 24'h00646e, 24'h00657f, 24'h008018, 24'h0081ad, 24'h00828f, 24'h009001};
  incr_jump_call_load_exec DUT (.ref_clk, .sys_rst, .mem_addr, .mem_rw, .mem_wdata, .mem_rdata, .bus_tick,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  mem_model u_mem (.ref_clk, .mem_addr, .mem_rw, .mem_wdata, .bus_tick, .mem_rdata);
  // Clock and hang guard.
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      test_done;
    end
  end
  task automatic test_done;
    if (fails == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; data are taken at the rising edge at which pready is seen high.
  // Only the bench timeout ends the wait, so a slave that never answers still fails.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic xe, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, q, exp);
    chk("pslverr", {31'h0, e}, {31'h0, xe});
  endtask
  // Main sequence.
  initial
  begin
    sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    fails = 0; num_checks = 0; cyc = 0; n = 0;
    for (int i = 0; i < 65536; i++) u_mem.ram[i] = 8'hee;
    for (int i = 0; i < 24; i++) u_mem.ram[i] = code[i];
    u_mem.ram[16'h0040] = 8'hf0;
    for (int i = 0; i < 14; i++) u_mem.ram[prog2[i][23:8]] = prog2[i][7:0];
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(REG_SP, 32'h00ff, 1'b0, "sp_rst");
    rd(REG_CCR, 32'hd0, 1'b0, "ccr_rst");
    rd(8'h20, 32'h0, 1'b1, "unmapped");
    apb(1'b1, REG_CCR, 32'hd1);
    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b1, REG_X, 32'h1234);
    repeat (300) @(posedge ref_clk);
    apb(1'b1, REG_CTRL, 32'h0);
    do begin apb(1'b0, REG_STATUS, 32'h0); n++; end while (q[STAT_BUSY] !== 1'b0 && n < 10);
    chk("status", q, 32'h0);
    rd(REG_PC, 32'h0015, 1'b0, "pc");
    rd(REG_SP, 32'h00fe, 1'b0, "sp");
    rd(REG_X, 32'h0001, 1'b0, "x");
    rd(REG_Y, 32'h0001, 1'b0, "y");
    rd(REG_ACC, 32'hf00b, 1'b0, "acc");
    rd(REG_CCR, 32'hd9, 1'b0, "ccr");
    chk("ret_lo", {24'h0, u_mem.ram[16'h0100]}, 32'h0b);
    chk("ret_hi", {24'h0, u_mem.ram[16'h00ff]}, 32'h00);
    // Second run from 0030: parks itself on the bad opcode at 0090.
    apb(1'b1, REG_PC, 32'h0030);
    apb(1'b1, REG_CTRL, 32'h1);
    repeat (300) @(posedge ref_clk);
    rd(REG_STATUS, 32'h2, 1'b0, "illegal");
    rd(REG_PC, 32'h0091, 1'b0, "pc2");
    rd(REG_SP, 32'h00fa, 1'b0, "sp2");
    rd(REG_ACC, 32'hf00b, 1'b0, "acc2");
    chk("ret_dir", {24'h0, u_mem.ram[16'h00fe]}, 32'h32);
    chk("ret_y", {24'h0, u_mem.ram[16'h00fc]}, 32'h83);
    chk("ret_y_hi", {24'h0, u_mem.ram[16'h00fb]}, 32'h00);
    apb(1'b1, REG_STATUS, 32'h2);
    rd(REG_STATUS, 32'h0, 1'b0, "illegal_clr");
    test_done;
  end
endmodule // incr_jump_call_load_exec_tb
